// File: xie_regs.svh
// Timing, field and reset constants for the exclusive-OR execute block.
`ifndef XIE_REGS_SVH
`define XIE_REGS_SVH
`define XIE_CLK_PERIOD_NS 10
`define XIE_OSC_PER_INSTR 4
`define XIE_INSTR_PERIOD_NS (`XIE_OSC_PER_INSTR * `XIE_CLK_PERIOD_NS)
`define XIE_INSTR_PERIOD_CYC (`XIE_INSTR_PERIOD_NS / `XIE_CLK_PERIOD_NS)
`define XIE_IMM_OPCODE 4'hF
`define XIE_IMM_OP_MSB 11
`define XIE_IMM_OP_LSB 8
`define XIE_REG_OPCODE 6'h06
`define XIE_REG_OP_MSB 11
`define XIE_REG_OP_LSB 6
`define XIE_DEST_BIT 5
`define XIE_FADDR_MSB 4
`define XIE_LIT_MSB 7
`define XIE_ACC_RESET 8'h00
`define XIE_ZERO_RESET 1'h0
`define XIE_INSTR_RESET 12'h000
`define XIE_FADDR_RESET 5'h00
`define XIE_FDATA_RESET 8'h00
`endif

// File: xie_pkg.sv
// Types shared by the exclusive-OR execute block.
package xie_pkg;
    typedef logic [11:0] xie_instr_t;
    typedef logic [7:0] xie_byte_t;
    typedef logic [4:0] xie_faddr_t;
    typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_EXEC, PH_DONE} xie_phase_t;
endpackage : xie_pkg

// File: xie_mem_if.sv
// Port bundle between the execute controller and the file-register memory.
interface xie_mem_if;
    import xie_pkg::*;
    xie_faddr_t addr;
    logic wrEn;
    xie_byte_t wrData;
    xie_byte_t rdData;
    modport ctrl (output addr, output wrEn, output wrData, input rdData);
    modport mem (input addr, input wrEn, input wrData, output rdData);
endinterface : xie_mem_if

// File: xie_file_mem.sv
// Thirty-two entry file-register memory with registered read data.
module xie_file_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8
) (
    input wire logic clk,
    xie_mem_if.mem port
);
    import xie_pkg::*;

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [WIDTH-1:0] rdData_q;
    logic [WIDTH-1:0] rdData_d;

    // Read is taken before the write of the same edge, so it returns the old word.
    always_comb
    begin
        rdData_d = store_q[port.addr];
    end

    // Storage holds no reset; software-visible contents are defined by preloads.
    always_ff @(posedge clk)
    begin
        rdData_q <= rdData_d;
        if (port.wrEn)
        begin
            store_q[port.addr] <= port.wrData;
        end
    end

    assign port.rdData = rdData_q;
endmodule : xie_file_mem

// File: xie_xor_execute.sv
// Execute datapath for the immediate and register exclusive-OR instructions.
// Function
// - Immediate opcode XORs accumulator with literal byte.
// - Register opcode XORs accumulator with addressed file.
// - Destination bit 0 writes accumulator, file unchanged.
// - Register-opcode destination bit 1 writes file, accumulator unchanged.
// - Each instruction takes four clock periods.
`include "xie_regs.svh"
module xie_xor_execute (
    input wire logic clk,
    input wire logic rst,
    input wire logic instrValid,
    input xie_pkg::xie_instr_t instrWord,
    input wire logic preloadEn,
    input xie_pkg::xie_faddr_t preloadAddr,
    input xie_pkg::xie_byte_t preloadData,
    output xie_pkg::xie_byte_t accOut,
    output logic zeroFlag,
    output logic busy,
    output logic done,
    output logic fileWrEn,
    output xie_pkg::xie_faddr_t fileWrAddr,
    output xie_pkg::xie_byte_t fileWrData
);
    import xie_pkg::*;

    // One instruction, counted from the edge that takes it:
    // the first phase puts the file address on the memory port,
    // the second sees the registered read word and forms the result,
    // the third shows done for one cycle while busy is still high.
    // A new word is therefore taken every fourth edge at the earliest,
    // so one instruction period is four clock periods.
    // Other opcodes are left alone so that the rest of the core
    // can share the instruction port with this block.

    // Carrier between this controller and the file-register memory.
    xie_mem_if memBus ();

    // Phase sequencer state.
    xie_phase_t phase_q;
    xie_phase_t phase_d;
    // Instruction word held for the whole period.
    xie_instr_t instr_q;
    xie_instr_t instr_d;
    // Architectural results.
    xie_byte_t acc_q;
    xie_byte_t acc_d;
    logic zero_q;
    logic zero_d;
    // Handshake and file write-back outputs.
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    logic fileWrEn_q;
    logic fileWrEn_d;
    xie_faddr_t fileWrAddr_q;
    xie_faddr_t fileWrAddr_d;
    xie_byte_t fileWrData_q;
    xie_byte_t fileWrData_d;
    // Datapath nets of the current phase.
    xie_byte_t result;
    logic isImm;
    logic toFile;

    // Opcode decode, used at fetch; the immediate decode is used again at execute.
    function automatic logic is_xor_imm(input xie_instr_t w);
        is_xor_imm = (w[`XIE_IMM_OP_MSB:`XIE_IMM_OP_LSB] == `XIE_IMM_OPCODE);
    endfunction : is_xor_imm

    function automatic logic is_xor_reg(input xie_instr_t w);
        is_xor_reg = (w[`XIE_REG_OP_MSB:`XIE_REG_OP_LSB] == `XIE_REG_OPCODE);
    endfunction : is_xor_reg

    // File address field, used by the read and by the write-back report.
    function automatic xie_faddr_t file_addr_of(input xie_instr_t w);
        file_addr_of = w[`XIE_FADDR_MSB:0];
    endfunction : file_addr_of

    // The file registers sit in their own memory with a registered read port.
    xie_file_mem #(
        .DEPTH(32),
        .WIDTH(8)
    ) fileMem (
        .clk(clk),
        .port(memBus)
    );

    // Operand select and the exclusive-OR itself.
    // The file operand is the registered read word, valid only in the execute phase,
    // so the result is not used in the other phases.
    always_comb
    begin
        isImm = is_xor_imm(instr_q);
        toFile = !isImm && instr_q[`XIE_DEST_BIT];
        if (isImm)
        begin
            result = acc_q ^ instr_q[`XIE_LIT_MSB:0];
        end
        else
        begin
            result = acc_q ^ memBus.rdData;
        end
    end

    // Memory port: preloads use it only while idle, so they never collide with a read.
    // The file write-back is issued in the execute phase, on the same edge at which
    // the accumulator would update, so either destination changes at one instant.
    always_comb
    begin
        memBus.addr = file_addr_of(instr_q);
        memBus.wrEn = 1'b0;
        memBus.wrData = result;
        if (phase_q == PH_FETCH)
        begin
            memBus.addr = preloadAddr;
            memBus.wrEn = preloadEn;
            memBus.wrData = preloadData;
        end
        else if (phase_q == PH_EXEC && toFile)
        begin
            memBus.wrEn = 1'b1;
        end
    end

    // Four-phase sequence; a new instruction is only taken in the fetch phase.
    always_comb
    begin
        // Defaults hold every register and keep the pulses low.
        phase_d = phase_q;
        instr_d = instr_q;
        acc_d = acc_q;
        zero_d = zero_q;
        done_d = 1'b0;
        fileWrEn_d = 1'b0;
        fileWrAddr_d = fileWrAddr_q;
        fileWrData_d = fileWrData_q;
        case (phase_q)
            // Idle: take a valid exclusive-OR word; other opcodes pass by.
            PH_FETCH:
            begin
                if (instrValid && (is_xor_imm(instrWord) || is_xor_reg(instrWord)))
                begin
                    instr_d = instrWord;
                    phase_d = PH_READ;
                end
            end
            // The file word is being read; nothing else happens.
            PH_READ:
            begin
                phase_d = PH_EXEC;
            end
            // The result lands in exactly one destination, and in the zero flag.
            PH_EXEC:
            begin
                zero_d = (result == 8'h00);
                if (toFile)
                begin
                    fileWrEn_d = 1'b1;
                    fileWrAddr_d = file_addr_of(instr_q);
                    fileWrData_d = result;
                end
                else
                begin
                    acc_d = result;
                end
                done_d = 1'b1;
                phase_d = PH_DONE;
            end
            // Busy is held one more cycle so that the period is four clocks.
            PH_DONE:
            begin
                phase_d = PH_FETCH;
            end
            default:
            begin
                phase_d = PH_FETCH;
            end
        endcase
        // Busy is known one edge ahead, so its output needs no extra stage.
        busy_d = (phase_d != PH_FETCH);
    end

    // State registers; the memory contents are not reset.
    // A reset in mid-instruction abandons it, though a file write due on that
    // same edge still lands, since the memory has no reset of its own.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            phase_q <= PH_FETCH;
            instr_q <= `XIE_INSTR_RESET;
            acc_q <= `XIE_ACC_RESET;
            zero_q <= `XIE_ZERO_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fileWrEn_q <= 1'b0;
            fileWrAddr_q <= `XIE_FADDR_RESET;
            fileWrData_q <= `XIE_FDATA_RESET;
        end
        else
        begin
            phase_q <= phase_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            zero_q <= zero_d;
            busy_q <= busy_d;
            done_q <= done_d;
            fileWrEn_q <= fileWrEn_d;
            fileWrAddr_q <= fileWrAddr_d;
            fileWrData_q <= fileWrData_d;
        end
    end

    // Every output comes straight from a register.
    assign accOut = acc_q;
    assign zeroFlag = zero_q;
    assign busy = busy_q;
    assign done = done_q;
    assign fileWrEn = fileWrEn_q;
    assign fileWrAddr = fileWrAddr_q;
    assign fileWrData = fileWrData_q;
endmodule : xie_xor_execute

// File: xie_asserts.sv
// Concurrent checks on the exclusive-OR execute block ports.
module xie_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic instrValid,
    input xie_pkg::xie_instr_t instrWord,
    input wire logic preloadEn,
    input xie_pkg::xie_faddr_t preloadAddr,
    input xie_pkg::xie_byte_t preloadData,
    input xie_pkg::xie_byte_t accOut,
    input wire logic zeroFlag,
    input wire logic busy,
    input wire logic done,
    input wire logic fileWrEn,
    input xie_pkg::xie_faddr_t fileWrAddr,
    input xie_pkg::xie_byte_t fileWrData
);
    timeunit 1ns;
    timeprecision 1ns;
    import xie_pkg::*;
    logic imm, regOp;
    // Decode of an instruction that is accepted at this edge.
    assign imm = !busy && instrValid && instrWord[11:8] == 4'hF;
    assign regOp = !busy && instrValid && instrWord[11:6] == 6'h06;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    imm_result_a: assert property (imm |-> ##3 done && accOut == ($past(accOut, 3) ^ $past(instrWord[7:0], 3))) else $error("immediate result wrong");
    reg_to_file_a: assert property (regOp && instrWord[5] |-> ##3 fileWrEn && fileWrAddr == $past(instrWord[4:0], 3) && $stable(accOut)) else $error("file destination wrong");
    reg_to_acc_a: assert property (regOp && !instrWord[5] |-> ##3 done && !fileWrEn) else $error("accumulator destination wrote file");
    cycle_len_a: assert property (imm || regOp |=> busy [*3] ##1 !busy) else $error("instruction length not four");
    done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
    zero_flag_a: assert property (done |-> zeroFlag == (fileWrEn ? fileWrData == 8'h00 : accOut == 8'h00)) else $error("zero flag wrong");
endmodule : xie_asserts
bind xie_xor_execute xie_asserts i_xie_asserts (
    .clk(clk),
    .rst(rst),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .preloadEn(preloadEn),
    .preloadAddr(preloadAddr),
    .preloadData(preloadData),
    .accOut(accOut),
    .zeroFlag(zeroFlag),
    .busy(busy),
    .done(done),
    .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr),
    .fileWrData(fileWrData)
);

// File: xie_issuer.sv
// Far-side issuer model: offers one instruction word and holds it until taken.
module xie_issuer (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input xie_pkg::xie_instr_t goWord,
    input wire logic busy,
    output logic instrValid,
    output xie_pkg::xie_instr_t instrWord
);
    timeunit 1ns;
    timeprecision 1ns;
    import xie_pkg::*;
    // The word is inverted once taken, so a stale word can never pass as fresh.
    always_ff @(posedge clk)
    begin
        if (rst)
            instrValid <= 1'b0;
        else if (go)
        begin
            instrValid <= 1'b1;
            instrWord <= goWord;
        end
        else if (instrValid && !busy)
        begin
            instrValid <= 1'b0;
            instrWord <= ~instrWord;
        end
    end
endmodule : xie_issuer

// File: xie_xor_execute_tb.sv
// Self-checking bench for the exclusive-OR execute block.
`include "xie_regs.svh"
module xie_xor_execute_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import xie_pkg::*;
    logic clk, rst, go, instrValid, preloadEn, zeroFlag, busy, done, fileWrEn;
    xie_instr_t goWord, instrWord;
    xie_faddr_t preloadAddr, fileWrAddr;
    xie_byte_t preloadData, accOut, fileWrData, acc;
    xie_byte_t mem [32];
    int mismatches, checks_done, cyc;
    xie_xor_execute i_xie_xor_execute (
        .clk(clk),
        .rst(rst),
        .instrValid(instrValid),
        .instrWord(instrWord),
        .preloadEn(preloadEn),
        .preloadAddr(preloadAddr),
        .preloadData(preloadData),
        .accOut(accOut),
        .zeroFlag(zeroFlag),
        .busy(busy),
        .done(done),
        .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData)
    );
    xie_issuer i_xie_issuer (
        .clk(clk),
        .rst(rst),
        .go(go),
        .goWord(goWord),
        .busy(busy),
        .instrValid(instrValid),
        .instrWord(instrWord)
    );
    // Free-running clock; 10 ns period.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input xie_byte_t seen, input xie_byte_t exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic pre(input xie_faddr_t a, input xie_byte_t d);
        @(posedge clk);
        preloadEn <= 1'b1;
        preloadAddr <= a;
        preloadData <= d;
        @(posedge clk);
        preloadEn <= 1'b0;
        mem[a] = d;
    endtask : pre
    // Issue one word, wait a bounded time for done, then judge every result.
    task automatic run(input xie_instr_t w);
        xie_byte_t r;
        int n;
        r = (w[11:8] == 4'hF) ? acc ^ w[7:0] : acc ^ mem[w[4:0]];
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        goWord <= w;
        @(posedge clk);
        go <= 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            n++;
            if (done === 1'b1)
                break;
        end
        chk({7'h00, done}, 8'h01);
        // Done shows at the take edge plus two, one period less the idle phase.
        chk(8'(n), 8'(`XIE_INSTR_PERIOD_CYC - 1));
        chk({7'h00, busy}, 8'h01);
        chk({7'h00, zeroFlag}, {7'h00, r == 8'h00});
        chk({7'h00, fileWrEn}, {7'h00, w[11:8] != 4'hF && w[5]});
        if (w[11:8] != 4'hF && w[5])
        begin
            chk(fileWrData, r);
            chk({3'h0, fileWrAddr}, {3'h0, w[4:0]});
            mem[w[4:0]] = r;
        end
        else
            acc = r;
        chk(accOut, acc);
        // Done stands one cycle, and busy drops at the fourth edge of the period.
        @(posedge clk);
        #1;
        chk({6'h00, busy, done}, 8'h00);
    endtask : run
    task automatic test_imm;
        run(12'hFB5);
        run(12'hFAF);
        run(12'hF1A);
        run(12'hFFF);
        $display("test immediate finished");
    endtask : test_imm
    task automatic test_reg;
        pre(5'h1F, 8'h3C);
        pre(5'h00, 8'h55);
        run(12'h19F);
        run(12'h1A0);
        run(12'h180);
        run(12'h1BF);
        run(12'h19F);
        $display("test register finished");
    endtask : test_reg
    // Reset between instructions: outputs return to reset values, the file memory keeps its words.
    task automatic test_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(accOut, `XIE_ACC_RESET);
        chk({7'h00, zeroFlag}, {7'h00, `XIE_ZERO_RESET});
        chk({6'h00, busy, done}, 8'h00);
        chk({7'h00, fileWrEn}, 8'h00);
        chk({3'h0, fileWrAddr}, {3'h0, `XIE_FADDR_RESET});
        chk(fileWrData, `XIE_FDATA_RESET);
        acc = `XIE_ACC_RESET;
        run(12'h19F);
        run(12'h1BF);
        $display("test reset finished");
    endtask : test_reset
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Hang guard well above the fewer than a hundred cycles the tests need.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            test_done();
        end
    end
    initial
    begin
        rst = 1'b1;
        go = 1'b0;
        goWord = 12'h000;
        preloadEn = 1'b0;
        preloadAddr = 5'h00;
        preloadData = 8'h00;
        acc = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        test_imm();
        test_reg();
        test_reset();
        test_done();
    end
endmodule : xie_xor_execute_tb
